// file: fps_pkg.sv
// Purpose: Shared constants, types and CRC step for the power-up and startup sequencer
// Assumes: One configuration clock at 200 MHz
// Notes:   Register offsets are word indices on the plain register port
package fps_pkg;
	localparam int CLK_MHZ       = 200;
	localparam int STAGGER_NS    = 50;
	localparam int STAGGER_CYC   = (STAGGER_NS * CLK_MHZ + 999) / 1000;
	localparam int REDUND_CYCLES = 17290;
	localparam int NUM_STEPS     = 32;
	localparam int NUM_FAB_RST   = 16;
	localparam int PREAMBLE_BITS = 512;
	localparam int PKT_BITS      = 128;
	localparam int PREAMBLE_PKTS = PREAMBLE_BITS / PKT_BITS;
	localparam int FUSE_WORDS    = 4;
	localparam int MODE_W        = 3;
	localparam int MODE_SETTLE   = 2;

	localparam logic [31:0] SYNC_WORD = 32'hAA55_AA55;
	localparam logic [31:0] CRC_INIT  = 32'hFFFF_FFFF;
	localparam logic [31:0] CRC_POLY  = 32'h04C1_1DB7;
	localparam logic [4:0]  LAST_STEP = 5'h1F;

	// Register word offsets
	localparam logic [3:0] OFS_CTRL    = 4'h0;
	localparam logic [3:0] OFS_PLLWAIT = 4'h1;
	localparam logic [3:0] OFS_PLLSEL  = 4'h2;
	localparam logic [3:0] OFS_CRC     = 4'h3;
	localparam logic [3:0] OFS_STATUS  = 4'h4;
	localparam logic [3:0] OFS_FUSE    = 4'h8;

	// Control field positions
	localparam int CTRL_CRC_EN   = 0;
	localparam int CTRL_SHUTDOWN = 1;
	localparam int CTRL_STAGE_LO = 2;

	// Values after reset
	localparam logic        CRC_EN_RST  = 1'b1;
	localparam logic [1:0]  STAGE_RST   = 2'h0;
	localparam logic [31:0] PLLWAIT_RST = 32'h0000_0000;
	localparam logic [3:0]  PLLSEL_RST  = 4'hF;

	typedef enum logic [3:0] {
		PH_MODE, PH_FUSE, PH_REDUND, PH_CLEAR, PH_SYNC, PH_ID, PH_PRE,
		PH_LOAD, PH_CRC, PH_STUP, PH_USER, PH_SHUT, PH_DISCARD
	} fps_phase_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [31:0] wdata;
	} fps_bus_t;

	typedef struct packed {
		logic         valid;
		logic [127:0] data;
	} fps_pkt_t;

	typedef struct packed {
		logic        we;
		logic [15:0] frame;
	} fps_clr_t;

	function automatic logic [31:0] fps_crc128(input logic [31:0] crcIn, input logic [127:0] d);
		logic [31:0] c;
		logic        fb;
		c = crcIn;
		for (int i = 127; i >= 0; i--)
		begin
			fb = c[31] ^ d[i];
			c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
		end
		return c;
	endfunction
endpackage

// file: fps_sync2.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Destination runs on mclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module fps_sync2 #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= din;
			sync_ff <= meta_ff;
		end
	end

	assign dout = sync_ff;
endmodule

// file: fps_seq.sv
// Purpose: Power-up, memory wipe, bitstream check and startup/shutdown sequencer
// Assumes: nrst is the configuration reset pin; all logic on the configuration clock
// Notes:   Bitstream packets and fuse data come from same-clock logic
// Contract
// - After release, read fuses into registers
// - Always spend 17290 cycles on redundancy shift
// - Step through 32 states, optional PLL wait
// - Last state waits for load-complete before operational
// - Wipe every configuration frame after fuse read
// - Skip-wipe pin bypasses the memory wipe
// - Raise wipe-finished pin when wipe completes
// - Wipe touches configuration frames only
// - Expect sync, ID codes, then 512-bit preamble
// - Bad sync or ID: discard stream, stay idle
// - Check device ID and 4-bit instance ID
// - CRC over 128-bit packets gates startup
// - CRC loads all ones on reset/write; readable
// - Idle, release resets in order, reverse on shutdown
// - Three stages; 16 fabric, 16 hard-IP resets
// - Operational flag means fully programmed fabric
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module fps_seq #(
	parameter int          REDUND_CYC  = fps_pkg::REDUND_CYCLES,
	parameter logic [15:0] FRAME_COUNT = 16'h0400,
	parameter logic [31:0] DEVICE_ID   = 32'h0DE5_1C0D, // Arbitrary value
	parameter logic [3:0]  INSTANCE_ID = 4'h5,          // Arbitrary value
	parameter logic [31:0] CRC_EXPECT  = 32'h0000_0000
) (
	input  wire logic                        mclk,
	input  wire logic                        nrst,
	input  wire fps_pkg::fps_bus_t           bus,
	output logic [31:0]                      rdata,
	input  wire logic [fps_pkg::MODE_W-1:0]  modeSelPins,
	input  wire logic                        skipWipePin,
	input  wire logic                        loadCompletePin,
	input  wire logic [3:0]                  pllLock,
	output logic                             fuseRdEn,
	output logic [1:0]                       fuseAddr,
	input  wire logic [31:0]                 fuseData,
	output logic                             redundShift,
	output fps_pkg::fps_clr_t                cmemClr,
	output logic                             wipeFinishedPin,
	input  wire fps_pkg::fps_pkt_t           bitIn,
	output fps_pkg::fps_pkt_t                secOut,
	output fps_pkg::fps_pkt_t                loadOut,
	output logic [fps_pkg::MODE_W-1:0]       cfgMode,
	output logic [15:0]                      fabricRstN,
	output logic [15:0]                      hardIpRstN,
	output logic                             operationalMode
);
	localparam logic [7:0] STAGGER8 = 8'(fps_pkg::STAGGER_CYC);

	fps_pkg::fps_phase_t          phase_ff;
	logic [31:0]                  cnt_ff;
	logic [4:0]                   stepIdx_ff;
	logic [7:0]                   gapCnt_ff;
	logic [fps_pkg::MODE_W-1:0]   modeS;
	logic                         skipS;
	logic                         doneS;
	logic [3:0]                   pllS;
	logic [fps_pkg::MODE_W-1:0]   cfgMode_ff;
	logic                         fuseRdEn_ff;
	logic [1:0]                   fuseAddr_ff;
	logic [31:0]                  fuseReg_ff [fps_pkg::FUSE_WORDS];
	logic                         fuseDone_ff;
	logic                         redundShift_ff;
	fps_pkg::fps_clr_t            cmemClr_ff;
	logic                         skipLat_ff;
	logic                         wipe_ff;
	fps_pkg::fps_pkt_t            secOut_ff;
	fps_pkg::fps_pkt_t            loadOut_ff;
	logic [31:0]                  crc_ff;
	logic                         crcEn_ff;
	logic [1:0]                   stage_ff;
	logic [31:0]                  pllWait_ff;
	logic [3:0]                   pllSel_ff;
	logic                         idErr_ff;
	logic                         crcFail_ff;
	logic [31:0]                  rstN_ff;
	logic                         user_ff;
	logic [31:0]                  rdata_ff;
	logic                         pktTaken;
	logic                         crcWr;
	logic                         shutReq;
	logic                         crcOk;
	logic                         stepReady;
	logic                         stepFire;
	logic                         hipHeld;

	fps_sync2 #(
		.W(fps_pkg::MODE_W + 6)
	) u_sync (
		.mclk (mclk),
		.nrst (nrst),
		.din  ({modeSelPins, skipWipePin, loadCompletePin, pllLock}),
		.dout ({modeS, skipS, doneS, pllS})
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decode and step conditions
	assign pktTaken = bitIn.valid && (phase_ff == fps_pkg::PH_ID || phase_ff == fps_pkg::PH_PRE
		|| phase_ff == fps_pkg::PH_LOAD);
	assign crcWr    = bus.wr && (bus.addr == fps_pkg::OFS_CRC);
	assign shutReq  = bus.wr && (bus.addr == fps_pkg::OFS_CTRL) && bus.wdata[fps_pkg::CTRL_SHUTDOWN];
	assign crcOk    = !crcEn_ff || (crc_ff == CRC_EXPECT);
	// PLL lock wait per state, and load-complete on the last state
	assign stepReady = (!pllWait_ff[stepIdx_ff] || ((pllS & pllSel_ff) == pllSel_ff))
		&& (stepIdx_ff != fps_pkg::LAST_STEP || doneS);
	assign stepFire = (gapCnt_ff == STAGGER8)
		&& ((phase_ff == fps_pkg::PH_STUP && stepReady) || phase_ff == fps_pkg::PH_SHUT);
	// Partial stages cycle fabric resets only; hard IP keeps its state
	assign hipHeld  = (stepIdx_ff >= 5'(fps_pkg::NUM_FAB_RST)) && (stage_ff != 2'h0);

	////////////////////////////////////////////////////////////////////////////////
	// Main phase sequencer
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			phase_ff   <= fps_pkg::PH_MODE;
			cnt_ff     <= 32'h0000_0000;
			stepIdx_ff <= 5'h00;
			gapCnt_ff  <= 8'h00;
			skipLat_ff <= 1'b0;
			idErr_ff   <= 1'b0;
			crcFail_ff <= 1'b0;
		end
		else
		begin
			gapCnt_ff <= (gapCnt_ff == STAGGER8) ? gapCnt_ff : gapCnt_ff + 8'h01;
			case (phase_ff)
				fps_pkg::PH_MODE:
				begin
					// Synchroniser is filled after release, then mode is taken
					cnt_ff <= cnt_ff + 32'h0000_0001;
					if (cnt_ff == 32'(fps_pkg::MODE_SETTLE))
					begin
						cnt_ff   <= 32'h0000_0000;
						phase_ff <= fps_pkg::PH_FUSE;
					end
				end
				fps_pkg::PH_FUSE:
				begin
					cnt_ff <= cnt_ff + 32'h0000_0001;
					if (cnt_ff == 32'(fps_pkg::FUSE_WORDS - 1))
					begin
						cnt_ff   <= 32'h0000_0000;
						phase_ff <= fps_pkg::PH_REDUND;
					end
				end
				fps_pkg::PH_REDUND:
				begin
					cnt_ff <= cnt_ff + 32'h0000_0001;
					if (cnt_ff == 32'(REDUND_CYC - 1))
					begin
						cnt_ff     <= 32'h0000_0000;
						skipLat_ff <= skipS;
						phase_ff   <= skipS ? fps_pkg::PH_SYNC : fps_pkg::PH_CLEAR;
					end
				end
				fps_pkg::PH_CLEAR:
				begin
					cnt_ff <= cnt_ff + 32'h0000_0001;
					if (cnt_ff == 32'(FRAME_COUNT) - 32'h0000_0001)
					begin
						cnt_ff   <= 32'h0000_0000;
						phase_ff <= fps_pkg::PH_SYNC;
					end
				end
				fps_pkg::PH_SYNC:
				begin
					// Packets before the sync word are dropped
					if (bitIn.valid && bitIn.data[127:96] == fps_pkg::SYNC_WORD)
						phase_ff <= fps_pkg::PH_ID;
				end
				fps_pkg::PH_ID:
				begin
					if (bitIn.valid)
					begin
						if (bitIn.data[127:96] == DEVICE_ID && bitIn.data[95:92] == INSTANCE_ID)
						begin
							cnt_ff   <= 32'h0000_0000;
							phase_ff <= fps_pkg::PH_PRE;
						end
						else
						begin
							idErr_ff <= 1'b1;
							phase_ff <= fps_pkg::PH_DISCARD;
						end
					end
				end
				fps_pkg::PH_PRE:
				begin
					if (bitIn.valid)
					begin
						cnt_ff <= cnt_ff + 32'h0000_0001;
						if (cnt_ff == 32'(fps_pkg::PREAMBLE_PKTS - 1))
							phase_ff <= fps_pkg::PH_LOAD;
					end
				end
				fps_pkg::PH_LOAD:
				begin
					if (doneS)
						phase_ff <= fps_pkg::PH_CRC;
				end
				fps_pkg::PH_CRC:
				begin
					if (crcOk)
					begin
						stepIdx_ff <= 5'h00;
						gapCnt_ff  <= 8'h00;
						phase_ff   <= fps_pkg::PH_STUP;
					end
					else
					begin
						crcFail_ff <= 1'b1;
						phase_ff   <= fps_pkg::PH_DISCARD;
					end
				end
				fps_pkg::PH_STUP:
				begin
					if (stepFire)
					begin
						gapCnt_ff <= 8'h00;
						if (stepIdx_ff == fps_pkg::LAST_STEP)
							phase_ff <= fps_pkg::PH_USER;
						else
							stepIdx_ff <= stepIdx_ff + 5'h01;
					end
				end
				fps_pkg::PH_USER:
				begin
					if (shutReq)
					begin
						gapCnt_ff <= 8'h00;
						phase_ff  <= fps_pkg::PH_SHUT;
					end
				end
				fps_pkg::PH_SHUT:
				begin
					if (stepFire)
					begin
						gapCnt_ff <= 8'h00;
						if (stepIdx_ff == 5'h00)
							phase_ff <= fps_pkg::PH_SYNC;
						else
							stepIdx_ff <= stepIdx_ff - 5'h01;
					end
				end
				fps_pkg::PH_DISCARD:
					phase_ff <= fps_pkg::PH_DISCARD;
				default:
					phase_ff <= fps_pkg::PH_MODE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode capture, held until the next reset
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cfgMode_ff <= '0;
		else if (phase_ff == fps_pkg::PH_MODE && cnt_ff == 32'(fps_pkg::MODE_SETTLE))
			cfgMode_ff <= modeS;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fuse read-in; fuseData is valid in the cycle of fuseRdEn
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			fuseRdEn_ff <= 1'b0;
			fuseAddr_ff <= 2'h0;
			fuseDone_ff <= 1'b0;
			for (int i = 0; i < fps_pkg::FUSE_WORDS; i++)
				fuseReg_ff[i] <= 32'h0000_0000;
		end
		else
		begin
			fuseRdEn_ff <= (phase_ff == fps_pkg::PH_FUSE);
			fuseAddr_ff <= cnt_ff[1:0];
			if (fuseRdEn_ff)
			begin
				fuseReg_ff[fuseAddr_ff] <= fuseData;
				if (fuseAddr_ff == 2'(fps_pkg::FUSE_WORDS - 1))
					fuseDone_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Redundancy shift and configuration frame wipe
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			redundShift_ff <= 1'b0;
			cmemClr_ff     <= '0;
			wipe_ff        <= 1'b0;
		end
		else
		begin
			redundShift_ff   <= (phase_ff == fps_pkg::PH_REDUND);
			// One all-zero frame write per cycle; block and logic RAM untouched
			cmemClr_ff.we    <= (phase_ff == fps_pkg::PH_CLEAR);
			cmemClr_ff.frame <= cnt_ff[15:0];
			wipe_ff          <= wipe_ff || (phase_ff == fps_pkg::PH_SYNC);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Preamble to security, payload to loader
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			secOut_ff  <= '0;
			loadOut_ff <= '0;
		end
		else
		begin
			secOut_ff.valid  <= bitIn.valid && (phase_ff == fps_pkg::PH_PRE);
			secOut_ff.data   <= bitIn.data;
			loadOut_ff.valid <= bitIn.valid && (phase_ff == fps_pkg::PH_LOAD);
			loadOut_ff.data  <= bitIn.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Accumulated CRC; a write restarts it and wins over a packet
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			crc_ff <= fps_pkg::CRC_INIT;
		else if (crcWr)
			crc_ff <= fps_pkg::CRC_INIT;
		else if (crcEn_ff && pktTaken)
			crc_ff <= fps_pkg::fps_crc128(crc_ff, bitIn.data);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Staggered reset release and reverse reassertion
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rstN_ff <= 32'h0000_0000;
			user_ff <= 1'b0;
		end
		else
		begin
			if (stepFire && !hipHeld)
				rstN_ff[stepIdx_ff] <= (phase_ff == fps_pkg::PH_STUP);
			if (stepFire && phase_ff == fps_pkg::PH_STUP && stepIdx_ff == fps_pkg::LAST_STEP)
				user_ff <= 1'b1;
			else if (phase_ff == fps_pkg::PH_USER && shutReq)
				user_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register port
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			crcEn_ff   <= fps_pkg::CRC_EN_RST;
			stage_ff   <= fps_pkg::STAGE_RST;
			pllWait_ff <= fps_pkg::PLLWAIT_RST;
			pllSel_ff  <= fps_pkg::PLLSEL_RST;
		end
		else if (bus.wr)
		begin
			case (bus.addr)
				fps_pkg::OFS_CTRL:
				begin
					crcEn_ff <= bus.wdata[fps_pkg::CTRL_CRC_EN];
					stage_ff <= bus.wdata[fps_pkg::CTRL_STAGE_LO +: 2];
				end
				fps_pkg::OFS_PLLWAIT:
					pllWait_ff <= bus.wdata;
				fps_pkg::OFS_PLLSEL:
					pllSel_ff <= bus.wdata[3:0];
				default:
					pllSel_ff <= pllSel_ff;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			rdata_ff <= 32'h0000_0000;
		else if (bus.rd)
		begin
			case (bus.addr)
				fps_pkg::OFS_CTRL:    rdata_ff <= {28'h000_0000, stage_ff, 1'b0, crcEn_ff};
				fps_pkg::OFS_PLLWAIT: rdata_ff <= pllWait_ff;
				fps_pkg::OFS_PLLSEL:  rdata_ff <= {28'h000_0000, pllSel_ff};
				fps_pkg::OFS_CRC:     rdata_ff <= crc_ff;
				fps_pkg::OFS_STATUS:  rdata_ff <= {12'h000, 4'(phase_ff), 2'b00, cfgMode_ff,
					crcFail_ff, idErr_ff, fuseDone_ff, wipe_ff, user_ff, 1'b0, stepIdx_ff};
				4'h8, 4'h9, 4'hA, 4'hB: rdata_ff <= fuseReg_ff[bus.addr[1:0]];
				default:              rdata_ff <= 32'h0000_0000;
			endcase
		end
		else
			rdata_ff <= 32'h0000_0000;
	end

	assign rdata           = rdata_ff;
	assign cfgMode         = cfgMode_ff;
	assign fuseRdEn        = fuseRdEn_ff;
	assign fuseAddr        = fuseAddr_ff;
	assign redundShift     = redundShift_ff;
	assign cmemClr         = cmemClr_ff;
	assign wipeFinishedPin = wipe_ff;
	assign secOut          = secOut_ff;
	assign loadOut         = loadOut_ff;
	assign fabricRstN      = rstN_ff[15:0];
	assign hardIpRstN      = rstN_ff[31:16];
	assign operationalMode = user_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [31:0] hRedCnt;
	logic [15:0] hClrCnt;
	logic [7:0]  hSince;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			hRedCnt <= 32'h0000_0000;
			hClrCnt <= 16'h0000;
			hSince  <= 8'hFF;
		end
		else
		begin
			hRedCnt <= hRedCnt + {31'h0000_0000, redundShift_ff};
			hClrCnt <= hClrCnt + {15'h0000, cmemClr_ff.we};
			hSince  <= (fabricRstN != $past(fabricRstN)) ? 8'h00
				: ((hSince == 8'hFF) ? hSince : hSince + 8'h01);
		end
	end

	a_redund_length: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(redundShift_ff) |-> (hRedCnt == 32'(REDUND_CYC)))
		else $error("redundancy shift length wrong");
	a_wipe_after_fuse: assert property (@(posedge mclk) disable iff (!nrst)
		cmemClr_ff.we |-> fuseDone_ff)
		else $error("frame wipe before fuse read done");
	a_skip_no_wipe: assert property (@(posedge mclk) disable iff (!nrst)
		skipLat_ff |-> (!cmemClr_ff.we && hClrCnt == 16'h0000))
		else $error("frames wiped while bypassed");
	a_wipe_all_frames: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(wipe_ff) |-> (skipLat_ff || hClrCnt == FRAME_COUNT))
		else $error("wipe finished before all frames");
	a_crc_write_init: assert property (@(posedge mclk) disable iff (!nrst)
		crcWr |=> (crc_ff == fps_pkg::CRC_INIT))
		else $error("crc not reloaded on write");
	a_user_needs_done: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(user_ff) |-> ($past(doneS) && rstN_ff[31] == !$past(hipHeld)))
		else $error("operational mode without load complete");
	a_bad_crc_blocks: assert property (@(posedge mclk) disable iff (!nrst)
		(phase_ff == fps_pkg::PH_CRC && !crcOk) |=> (phase_ff == fps_pkg::PH_DISCARD)[*3])
		else $error("startup began with bad crc");
	a_discard_idle: assert property (@(posedge mclk) disable iff (!nrst)
		(phase_ff == fps_pkg::PH_DISCARD) |=> (!loadOut_ff.valid && !secOut_ff.valid
		&& rstN_ff == $past(rstN_ff)))
		else $error("activity after stream discarded");
	a_mode_hold: assert property (@(posedge mclk) disable iff (!nrst)
		(phase_ff != fps_pkg::PH_MODE) |=> $stable(cfgMode_ff))
		else $error("mode changed after capture");
	a_fabric_stagger: assert property (@(posedge mclk) disable iff (!nrst)
		(fabricRstN != $past(fabricRstN)) |-> (hSince >= STAGGER8))
		else $error("fabric resets not staggered");
	a_shutdown_exit: assert property (@(posedge mclk) disable iff (!nrst)
		(phase_ff == fps_pkg::PH_USER && shutReq) |=> (!user_ff && phase_ff == fps_pkg::PH_SHUT))
		else $error("shutdown request not taken");
endmodule

// file: fps_host_model.sv
// Purpose: Host and fuse model facing the power-up and startup sequencer
// Assumes: The bench makes mclk and keeps it running through every test
// Notes:   Idle packet data is the inverse of the last packet, so stale use shows
`timescale 1ns/100ps
module fps_host_model (
	input  wire logic                   mclk,
	input  wire logic [1:0]             fuseAddr,
	output logic                        nrst,
	output logic [fps_pkg::MODE_W-1:0]  modeSelPins,
	output logic                        skipWipePin,
	output logic [3:0]                  pllLock,
	output logic [31:0]                 fuseData,
	output fps_pkg::fps_pkt_t           bitIn
);
	initial
	begin
		nrst = 1'b0;
		modeSelPins = 3'h0;
		skipWipePin = 1'b0;
		pllLock = 4'hF;
		bitIn = '0;
	end

	// Fuse words carry their own address
	assign fuseData = {16'hA5C3, 14'h0000, fuseAddr};

	task automatic powerUp(input logic [fps_pkg::MODE_W-1:0] m, input logic s);
		@(posedge mclk);
		nrst <= 1'b0;
		modeSelPins <= m;
		skipWipePin <= s;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
	endtask

	task automatic setLock(input logic [3:0] l);
		pllLock <= l;
	endtask

	task automatic sendPkt(input logic [127:0] d);
		@(posedge mclk);
		bitIn <= '{valid: 1'b1, data: d};
		@(posedge mclk);
		bitIn <= '{valid: 1'b0, data: ~d};
	endtask
endmodule

// file: test_fpga_config_powerup_startup_seq.sv
// Purpose: Self-checking bench for the power-up and startup sequencer
// Assumes: Short redundancy and frame counts through parameters
// Notes:   Packet counters clear on every reset
`timescale 1ns/100ps
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] %0t %h %h", $time, (a), (b)); end end
module test_fpga_config_powerup_startup_seq;
	localparam logic [31:0] DEV_ID = 32'h1234_5678; // Arbitrary value
	localparam logic [3:0]  INST_ID = 4'h9;         // Arbitrary value
	logic               mclk = 1'b0;
	logic               nrst;
	fps_pkg::fps_bus_t  bus = '0;
	logic [31:0]        rdata;
	logic [2:0]         modeSelPins;
	logic               skipWipePin;
	logic               loadCompletePin = 1'b0;
	logic [3:0]         pllLock;
	logic               fuseRdEn;
	logic [1:0]         fuseAddr;
	logic [31:0]        fuseData;
	logic               redundShift;
	fps_pkg::fps_clr_t  cmemClr;
	logic               wipeFinishedPin;
	fps_pkg::fps_pkt_t  bitIn;
	fps_pkg::fps_pkt_t  secOut;
	fps_pkg::fps_pkt_t  loadOut;
	logic [2:0]         cfgMode;
	logic [15:0]        fabricRstN;
	logic [15:0]        hardIpRstN;
	logic               operationalMode;
	int                 mismatches = 0;
	int                 totalChecks = 0;
	int                 cyc = 0;
	int                 fuseCnt, redCnt, weCnt, secCnt, ldCnt;
	logic [31:0]        v;
	int                 n;

	initial
	begin
		forever #2.5 mclk = ~mclk;
	end

	fps_seq #(.REDUND_CYC(20), .FRAME_COUNT(16'h0008), .DEVICE_ID(DEV_ID),
		.INSTANCE_ID(INST_ID), .CRC_EXPECT(32'hFFFF_FFFF)) u_dut (.mclk(mclk), .nrst(nrst),
		.bus(bus), .rdata(rdata),
		.modeSelPins(modeSelPins), .skipWipePin(skipWipePin),
		.loadCompletePin(loadCompletePin), .pllLock(pllLock), .fuseRdEn(fuseRdEn),
		.fuseAddr(fuseAddr), .fuseData(fuseData), .redundShift(redundShift),
		.cmemClr(cmemClr), .wipeFinishedPin(wipeFinishedPin), .bitIn(bitIn),
		.secOut(secOut), .loadOut(loadOut), .cfgMode(cfgMode), .fabricRstN(fabricRstN),
		.hardIpRstN(hardIpRstN), .operationalMode(operationalMode));

	fps_host_model u_host (.mclk(mclk), .fuseAddr(fuseAddr), .nrst(nrst),
		.modeSelPins(modeSelPins), .skipWipePin(skipWipePin), .pllLock(pllLock),
		.fuseData(fuseData), .bitIn(bitIn));

	////////////////////////////////////////////////////////////////////////////////
	// Output monitors
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			{fuseCnt, redCnt, weCnt, secCnt, ldCnt} <= '0;
		end
		else
		begin
			fuseCnt <= fuseCnt + int'(fuseRdEn);
			redCnt <= redCnt + int'(redundShift);
			secCnt <= secCnt + int'(secOut.valid);
			ldCnt <= ldCnt + int'(loadOut.valid);
			if (secOut.valid === 1'b1)
				`CHK(secOut.data, {32'(secCnt), 96'h5})
			if (loadOut.valid === 1'b1)
				`CHK(loadOut.data, 128'h0F0F)
			if (cmemClr.we === 1'b1)
			begin
				`CHK(cmemClr.frame, 16'(weCnt))
				weCnt <= weCnt + 1;
			end
		end
	end

	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			mismatches++;
			giveVerdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register port
	task automatic regWr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		bus <= '0;
	endtask

	task automatic regRd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
		@(posedge mclk);
		bus <= '0;
		#1 d = rdata;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic powerUpWipe();
		u_host.powerUp(3'h2, 1'b0);
		for (n = 0; n < 300 && wipeFinishedPin !== 1'b1; n++) @(posedge mclk);
		`CHK(wipeFinishedPin, 1'b1)
		`CHK(cfgMode, 3'h2)
		`CHK(fuseCnt, 4)
		`CHK(redCnt, 20)
		`CHK(weCnt, 8)
		for (int i = 0; i < 4; i++)
		begin
			regRd(4'(8 + i), v);
			`CHK(v, {16'hA5C3, 14'h0000, 2'(i)})
		end
		regRd(fps_pkg::OFS_STATUS, v);
		`CHK({v[13:11], v[8:7]}, 5'h0B)
		regRd(4'hF, v);
		`CHK(v, 32'h0000_0000)
	endtask

	task automatic loadAndStart();
		regWr(fps_pkg::OFS_CTRL, 32'h0000_0001);
		u_host.sendPkt({fps_pkg::SYNC_WORD, 96'h0});
		u_host.sendPkt({DEV_ID, INST_ID, 92'h0});
		for (int i = 0; i < 4; i++) u_host.sendPkt({32'(i), 96'h5});
		u_host.sendPkt({128'h0F0F});
		repeat (2) @(posedge mclk);
		`CHK(secCnt, 4)
		`CHK(ldCnt, 1)
		regRd(fps_pkg::OFS_CRC, v);
		`CHK(v != fps_pkg::CRC_INIT, 1'b1)
		regWr(fps_pkg::OFS_CRC, 32'h0000_0000);
		regRd(fps_pkg::OFS_CRC, v);
		`CHK(v, fps_pkg::CRC_INIT)
		// Step 0 waits on a PLL held unlocked
		u_host.setLock(4'hD);
		regWr(fps_pkg::OFS_PLLWAIT, 32'h0000_0001);
		regWr(fps_pkg::OFS_PLLSEL, 32'h0000_0002);
		@(posedge mclk);
		loadCompletePin <= 1'b1;
		repeat (40) @(posedge mclk);
		`CHK(fabricRstN, 16'h0000)
		u_host.setLock(4'hF);
		for (n = 0; n < 1000 && operationalMode !== 1'b1; n++) @(posedge mclk);
		`CHK(n >= 31 * (fps_pkg::STAGGER_CYC + 1), 1'b1)
		`CHK(operationalMode, 1'b1)
		`CHK({fabricRstN, hardIpRstN}, 32'hFFFF_FFFF)
	endtask

	task automatic shutDown();
		regWr(fps_pkg::OFS_CTRL, 32'h0000_0002);
		@(posedge mclk);
		#1 `CHK(operationalMode, 1'b0)
		for (n = 0; n < 1000 && fabricRstN !== 16'h0000; n++) @(posedge mclk);
		`CHK({fabricRstN, hardIpRstN}, 32'h0000_0000)
		regRd(fps_pkg::OFS_STATUS, v);
		`CHK(v[19:16], 4'h4)
	endtask

	task automatic skipAndBadId();
		loadCompletePin <= 1'b0;
		u_host.powerUp(3'h5, 1'b1);
		for (n = 0; n < 300 && wipeFinishedPin !== 1'b1; n++) @(posedge mclk);
		`CHK(wipeFinishedPin, 1'b1)
		`CHK(weCnt, 0)
		`CHK(cfgMode, 3'h5)
		u_host.sendPkt({fps_pkg::SYNC_WORD, 96'h0});
		u_host.sendPkt({DEV_ID, ~INST_ID, 92'h0});
		u_host.sendPkt(128'h0);
		regRd(fps_pkg::OFS_STATUS, v);
		`CHK({v[19:16], v[9]}, 5'h19)
		`CHK(secCnt, 0)
		`CHK(ldCnt, 0)
	endtask

	task automatic giveVerdict();
		if (mismatches == 0 && totalChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		powerUpWipe();
		loadAndStart();
		shutDown();
		skipAndBadId();
		giveVerdict();
	end
endmodule
